// ==== hw/bank_status_pkg.sv ====
// Purpose: Shared constants and carriers of the bank status encoder
// Assumes: One core clock, APB register access, 32-bit data
// Notes: Status bit positions are those of the 64-bit status word
`default_nettype none
package bank_status_pkg;
  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_STAT_LO = 8'h00;
  localparam logic [7:0] OFS_STAT_HI = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  localparam logic [31:0] CTRL_RESET = 32'h0000_FF00;
  // Control field positions
  localparam int CTRL_FMT_LO = 0;
  localparam int CTRL_MISC_VALID_FLAG = 2;
  localparam int CTRL_TRACK = 3;
  localparam int CTRL_THR_LO = 8;
  // ------------------------------------------------------------
  // Status word fields
  // ------------------------------------------------------------
  localparam int ST_CNT_LO = 32;
  localparam int ST_FMT_LO = 40;
  localparam int ST_SYN_LO = 44;
  localparam int ST_SYNV = 52;
  localparam int ST_THR_LO = 53;
  localparam int ST_PCC = 57;
  localparam int ST_MISC_VALID_FLAG = 59;
  localparam int ST_UC = 61;
  localparam int ST_OVER = 62;
  localparam int ST_VAL = 63;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  // Architectural error codes
  localparam logic [15:0] CODE_L3 = 16'h010B;
  localparam logic [15:0] CODE_BUS = 16'h0E0F;
  // Fixed upper pattern of an L3 sub-code, bits 31:21
  localparam logic [10:0] L3_PATTERN = 11'h100;
  // L3 sub-codes
  localparam logic [2:0] L3_NONE = 3'h0;
  localparam logic [2:0] L3_MULTI_CORR = 3'h1;
  localparam logic [2:0] L3_MULTI_UNC = 3'h2;
  localparam logic [2:0] L3_MULTI_TAG = 3'h3;
  localparam logic [2:0] L3_ONE_CORR = 3'h5;
  localparam logic [2:0] L3_ONE_UNC = 3'h6;
  localparam logic [2:0] L3_MIXED = 3'h7;
  // Health status codes
  localparam logic [1:0] HEALTH_NONE = 2'h0;
  localparam logic [1:0] HEALTH_BELOW = 2'h1;
  localparam logic [1:0] HEALTH_ABOVE = 2'h2;
  // Bus cause index; cause bit i reports at status bit 16 + i
  localparam int BUS_ECC_IDX = 9;
  // Bits 16..27 of a bus code that may be set (19 reserved)
  localparam logic [11:0] BUS_CAUSE_MASK = 12'hFF7;

  typedef enum logic {KIND_L3, KIND_BUS} err_kind_e;

  // One detected error event, valid for one cycle
  typedef struct packed {
    logic valid;
    err_kind_e kind;
    logic l3_corr_any;
    logic l3_corr_multi;
    logic l3_unc_any;
    logic l3_unc_multi;
    logic l3_tag_multi;
    logic [11:0] bus_cause;
    logic ecc_uncorr;
    logic synd_given;
    logic [7:0] syndrome;
  } err_event_s;

  // Encoded result for the low word and flags
  typedef struct packed {
    logic [31:0] code;
    logic uc;
    logic synd_ok;
  } err_code_s;
endpackage : bank_status_pkg
`default_nettype wire

// ==== hw/bank_code_formatter.sv ====
// Purpose: Encodes one error event into the low status word
// Assumes: Event fields are stable in the cycle valid is high
// Notes: Purely combinational; the caller registers the result
`default_nettype none
module bank_code_formatter
  import bank_status_pkg::*;
(
  input wire err_event_s ev,
  output err_code_s res
);
  // ------------------------------------------------------------
  // Encoding
  // ------------------------------------------------------------
  logic [2:0] l3_sub;
  logic [11:0] cause_ok;
  logic [11:0] onehot;
  logic [11:0] bus_bits;

  // L3 way summary to sub-code
  always_comb begin
    if (ev.l3_corr_any && ev.l3_unc_any) begin
      l3_sub = L3_MIXED;
    end else if (ev.l3_unc_multi) begin
      l3_sub = L3_MULTI_UNC;
    end else if (ev.l3_corr_multi) begin
      l3_sub = L3_MULTI_CORR;
    end else if (ev.l3_tag_multi) begin
      l3_sub = L3_MULTI_TAG;
    end else if (ev.l3_unc_any) begin
      l3_sub = L3_ONE_UNC;
    end else if (ev.l3_corr_any) begin
      l3_sub = L3_ONE_CORR;
    end else begin
      l3_sub = L3_NONE;
    end
  end

  // Lowest set cause wins so exactly one bit survives
  // Reserved cause position 3 never reaches the status word
  assign cause_ok = ev.bus_cause & BUS_CAUSE_MASK;
  assign onehot = cause_ok & (~cause_ok + 12'h001);
  assign bus_bits = onehot;

  // Assemble code, uncorrected flag and syndrome qualifier
  always_comb begin
    res = '0;
    if (ev.kind == KIND_L3) begin
      res.code = {L3_PATTERN, 2'h0, l3_sub, CODE_L3};
      res.uc = ev.l3_unc_any;
    end else begin
      res.code = {4'h0, bus_bits, CODE_BUS};
      // Only the inbound ECC cause can be corrected
      res.uc = !onehot[BUS_ECC_IDX] || ev.ecc_uncorr;
    end
    res.synd_ok = !res.uc && ev.synd_given;
  end
endmodule : bank_code_formatter
`default_nettype wire

// ==== hw/bank_status_encoder.sv ====
// Purpose: Logs error events into a 64-bit bank status word
// Assumes: APB slave with one wait state; single clock domain
// Notes: Status valid and overflow clear by writing zero to them
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`default_nettype none
// Contract
// - Supplementary field sits at bits 56:32, same for all error types.
// - Bits 39:32 count corrected events: first gives 1, saturates at 255.
// - Bits 41:40 give the misc layout code, meaningful with misc-valid.
// - Bits 51:44 hold the ECC syndrome when syndrome-valid is set.
// - Bit 52 set only when the corrected event supplied a syndrome.
// - Bits 54:53: 00 untracked, 01 below, 10 above threshold, 11 unused.
// - L3 bits 18:16 encode way summary of the error.
// - L3 code carries 00 at bits 20:19 and fixed pattern at 31:21.
// - Bus bits 16..18: request phase, core 0 and core 1 address parity.
// - Bus bits 20..23: response, inbound data, core 0, core 1 data parity.
// - Bus bit 24 flags enhanced-defer signal parity in either phase.
// - Bus bit 25 flags inbound data ECC, corrected or not.
// - Bus bits 26 and 27 flag data and request strobe glitches.
// - A logged bus error has exactly one cause bit set.
// - Only inbound data ECC may be corrected; other bus causes uncorrected.
// - Low 16 bits are the L3 or the bus architectural code.
// - Bit 61 set when the error was not corrected, else clear.
// - Bit 59 set only when the misc register holds more information.
module bank_status_encoder
  import bank_status_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire err_event_s err_event,
  output logic [63:0] bank_status
);
  // ------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------
  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [63:0] status_q;
  logic [63:0] status_d;
  logic [31:0] ctrl_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  err_code_s enc;
  logic access;
  logic done;
  logic wr_hi;
  logic wr_ctrl;
  logic log_new;
  logic corr_event;
  logic [7:0] cnt_d;
  logic [1:0] health;
  logic keep_val;
  logic keep_over;

  // Address match on the low byte of the byte address
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] ofs);
    hit = (a[7:0] == ofs);
  endfunction : hit

  // Apply byte strobes to a 32-bit register image
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // ------------------------------------------------------------
  // Event encoder
  // ------------------------------------------------------------
  bank_code_formatter u_fmt (
    .ev(err_event),
    .res(enc)
  );

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // First access cycle prepares the answer
  assign access = psel && penable && !pready_q;
  // Writes land only at the edge that ends the transfer
  assign done = psel && penable && pready_q;
  assign wr_hi = done && pwrite && hit(paddr, OFS_STAT_HI);
  assign wr_ctrl = done && pwrite && hit(paddr, OFS_CTRL);

  // ------------------------------------------------------------
  // Logging decision
  // ------------------------------------------------------------
  // Valid and overflow bits as they stand after a software write
  always_comb begin
    keep_val = status_q[ST_VAL];
    keep_over = status_q[ST_OVER];
    if (wr_hi && pstrb[3]) begin
      keep_val = keep_val && pwdata[ST_VAL-32];
      keep_over = keep_over && pwdata[ST_OVER-32];
    end
  end

  // Uncorrected replaces corrected; uncorrected is never replaced
  assign log_new = err_event.valid &&
                   (!status_q[ST_VAL] ||
                    (enc.uc && !status_q[ST_UC]));
  assign corr_event = err_event.valid && !enc.uc;

  // Saturating count of corrected events since reset
  always_comb begin
    cnt_d = status_q[ST_CNT_LO +: 8];
    if (corr_event && cnt_d != CNT_MAX) begin
      cnt_d = cnt_d + 8'h01;
    end
  end

  // Health against the programmed threshold
  always_comb begin
    if (!ctrl_q[CTRL_TRACK]) begin
      health = HEALTH_NONE;
    end else if (cnt_d > ctrl_q[CTRL_THR_LO +: 8]) begin
      health = HEALTH_ABOVE;
    end else begin
      health = HEALTH_BELOW;
    end
  end

  // Next status word; reserved positions always stay zero
  always_comb begin
    status_d = status_q;
    status_d[ST_VAL] = keep_val;
    status_d[ST_OVER] = keep_over;
    status_d[ST_CNT_LO +: 8] = cnt_d;
    status_d[ST_THR_LO +: 2] = health;
    if (log_new) begin
      status_d[31:0] = enc.code;
      status_d[ST_UC] = enc.uc;
      status_d[ST_PCC] = enc.uc;
      status_d[ST_MISC_VALID_FLAG] = ctrl_q[CTRL_MISC_VALID_FLAG];
      status_d[ST_FMT_LO +: 2] = ctrl_q[CTRL_MISC_VALID_FLAG] ?
                                 ctrl_q[CTRL_FMT_LO +: 2] : 2'h0;
      status_d[ST_SYNV] = enc.synd_ok;
      status_d[ST_SYN_LO +: 8] = enc.synd_ok ?
                                 err_event.syndrome : 8'h00;
    end
    // New event sets valid, and overflow if one was pending
    if (err_event.valid) begin
      status_d[ST_VAL] = 1'b1;
      if (status_q[ST_VAL]) begin
        status_d[ST_OVER] = 1'b1;
      end
    end
    status_d[43:42] = 2'h0;
    status_d[56:55] = 2'h0;
    status_d[60] = 1'b0;
    status_d[58] = 1'b0;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Status word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 64'h0;
    end else begin
      status_q <= status_d;
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= merge(ctrl_q, pwdata, pstrb) & 32'h0000_FF0F;
    end
  end

  // APB answer: one wait state, unmapped gives an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= access;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
      if (access) begin
        if (hit(paddr, OFS_STAT_LO)) begin
          pslverr_q <= pwrite;
          if (!pwrite) begin
            prdata_q <= status_q[31:0];
          end
        end else if (hit(paddr, OFS_STAT_HI)) begin
          if (!pwrite) begin
            prdata_q <= status_q[63:32];
          end
        end else if (hit(paddr, OFS_CTRL)) begin
          if (!pwrite) begin
            prdata_q <= ctrl_q;
          end
        end else if (hit(paddr, OFS_COUNT)) begin
          pslverr_q <= pwrite;
          if (!pwrite) begin
            prdata_q <= {24'h0, status_q[ST_CNT_LO +: 8]};
          end
        end else begin
          pslverr_q <= 1'b1;
        end
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign bank_status = status_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_answer;
    psel && penable && !pready ##1 pready;
  endsequence

  logic is_bus;
  assign is_bus = status_q[ST_VAL] && status_q[15:0] == CODE_BUS;

  a_apb_one_wait: assert property (s_setup ##1 psel |-> s_answer)
    else $error("APB answer not after one wait state");

  a_count_step: assert property (corr_event && !wr_hi &&
      status_q[39:32] != CNT_MAX |=>
      status_q[39:32] == $past(status_q[39:32]) + 8'h01)
    else $error("Corrected count did not advance by one");

  a_count_hold_max: assert property (status_q[39:32] == CNT_MAX |=>
      status_q[39:32] == CNT_MAX)
    else $error("Corrected count left saturation");

  a_bus_onehot: assert property (is_bus |->
      $onehot(status_q[27:16]) && !status_q[19])
    else $error("Bus cause bits not one-hot");

  a_bus_uc_rule: assert property (is_bus && !status_q[25] |->
      status_q[ST_UC])
    else $error("Non-ECC bus cause logged as corrected");

  a_l3_pattern: assert property (status_q[ST_VAL] &&
      status_q[15:0] == CODE_L3 |->
      status_q[31:19] == {L3_PATTERN, 2'h0})
    else $error("L3 fixed pattern wrong");

  a_synd_qual: assert property (status_q[ST_SYNV] |->
      !status_q[ST_UC])
    else $error("Syndrome valid on uncorrected error");

  a_health_legal: assert property (status_q[54:53] != 2'h3)
    else $error("Health code illegal");

  a_health_untracked: assert property (!ctrl_q[CTRL_TRACK] |=>
      status_q[54:53] == HEALTH_NONE)
    else $error("Health shown without tracking");

  a_reserved_zero: assert property (status_q[43:42] == 2'h0 &&
      status_q[56:55] == 2'h0)
    else $error("Reserved status bits not zero");

  a_log_uc_flag: assert property (log_new |=>
      status_q[ST_UC] == $past(enc.uc) &&
      status_q[ST_MISC_VALID_FLAG] == $past(ctrl_q[CTRL_MISC_VALID_FLAG]))
    else $error("Uncorrected or misc-valid flag mislogged");

  a_misc_fmt_zero: assert property (!status_q[ST_MISC_VALID_FLAG] |->
      status_q[41:40] == 2'h0)
    else $error("Misc format shown without misc-valid");

  a_synd_zero: assert property (!status_q[ST_SYNV] |->
      status_q[51:44] == 8'h00)
    else $error("Syndrome shown without its valid flag");

  a_val_set: assert property (err_event.valid |=> status_q[ST_VAL])
    else $error("Event did not set valid");

  a_over_set: assert property (err_event.valid && status_q[ST_VAL] |=>
      status_q[ST_OVER])
    else $error("Event on valid entry did not set overflow");

  a_pcc_match: assert property (status_q[ST_PCC] == status_q[ST_UC])
    else $error("Context flag differs from uncorrected flag");

  a_ro_write_err: assert property (access && pwrite &&
      hit(paddr, OFS_STAT_LO) |=> pslverr)
    else $error("Write to read-only word not refused");
endmodule : bank_status_encoder
`default_nettype wire

// ==== testbench/bank_status_encoder_test.sv ====
// Purpose: Self-checking bench for the bank status encoder
// Assumes: APB answers with one wait state; events last one cycle each, except one run of 300 cycles
// Notes: Expected words are built from the package constants and literal values
`default_nettype none
module bank_status_encoder_test
  import bank_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [63:0] bank_status;
  err_event_s err_event, ev;
  int n_fail, comparisons, cyc, p;
  // L3 way flags {corr_any, corr_multi, unc_any, unc_multi, tag_multi}
  logic [4:0] fl [6] = '{5'h10, 5'h18, 5'h04, 5'h06, 5'h14, 5'h01};
  logic [2:0] cd [6] = '{L3_ONE_CORR, L3_MULTI_CORR, L3_ONE_UNC,
                         L3_MULTI_UNC, L3_MIXED, L3_MULTI_TAG};
  logic [1:0] ux [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2};

  bank_status_encoder #(.ADDR_W(8)) bank_status_encoder_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .err_event(err_event), .bank_status(bank_status));

  // Clock at 20 MHz
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Cuts a hung run short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic results;
    $display("Mismatches %0d of %0d comparisons", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  task automatic cmp(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Holds one event valid for n edges
  task automatic fire(input err_event_s e, input int n);
    @(posedge pclk);
    err_event <= e;
    repeat (n) @(posedge pclk);
    err_event <= '0;
    @(posedge pclk);
  endtask : fire

  // Clears valid and overflow, then logs one event
  task automatic post(input err_event_s e);
    apb(1'b1, OFS_STAT_HI, 32'h0, 4'h8);
    fire(e, 1);
    cmp({bank_status[56:55], bank_status[43:42]}, 4'h0);
  endtask : post

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    err_event = '0;
    {n_fail, comparisons, cyc} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and refused accesses
    apb(1'b0, OFS_CTRL, 32'h0, 4'h0);
    cmp(rd, CTRL_RESET);
    cmp(bank_status, 64'h0);
    apb(1'b0, 8'h10, 32'h0, 4'h0);
    cmp(er, 1'b1);
    apb(1'b1, OFS_STAT_LO, 32'hFFFF_FFFF, 4'hF);
    cmp(er, 1'b1);
    // L3 sub-codes; the first corrected event counts as one
    for (int i = 0; i < 6; i++) begin
      ev = '0;
      ev.valid = 1'b1;
      ev.kind = KIND_L3;
      {ev.l3_corr_any, ev.l3_corr_multi, ev.l3_unc_any, ev.l3_unc_multi,
       ev.l3_tag_multi} = fl[i];
      post(ev);
      if (i == 0) cmp(bank_status[39:32], 8'h01);
      cmp(bank_status[31:0], {L3_PATTERN, 2'b00, cd[i], CODE_L3});
      if (ux[i] != 2'h2) cmp(bank_status[61], ux[i][0]);
    end
    // Bus causes, all offered as corrected; cause i reports at 16 + i
    for (int i = 0; i < 12; i++) begin
      if (i == 3) continue;
      ev = '0;
      ev.valid = 1'b1;
      ev.kind = KIND_BUS;
      ev.bus_cause = 12'h001 << i;
      post(ev);
      p = 16 + i;
      cmp(bank_status[31:0], (32'h1 << p) | CODE_BUS);
      cmp(bank_status[61], p != 25);
    end
    // Several causes at once: reserved position dropped, lowest kept
    ev.bus_cause = 12'h20C;
    post(ev);
    cmp(bank_status[31:0], (32'h1 << 18) | CODE_BUS);
    // Syndrome with corrected, uncorrected and absent cases
    ev.bus_cause = 12'h200;
    ev.synd_given = 1'b1;
    ev.syndrome = 8'hA5;
    post(ev);
    cmp(bank_status[52:44], 9'h1A5);
    ev.ecc_uncorr = 1'b1;
    post(ev);
    cmp({bank_status[61], bank_status[52]}, 2'b10);
    ev.ecc_uncorr = 1'b0;
    ev.synd_given = 1'b0;
    post(ev);
    cmp(bank_status[52], 1'b0);
    // Misc layout code and its valid flag
    ev = '0;
    ev.valid = 1'b1;
    ev.kind = KIND_L3;
    ev.l3_corr_any = 1'b1;
    apb(1'b1, OFS_CTRL, 32'h0000_FF06, 4'hF);
    post(ev);
    cmp({bank_status[59], bank_status[41:40]}, 3'b110);
    apb(1'b1, OFS_CTRL, 32'h0000_FF01, 4'hF);
    post(ev);
    cmp(bank_status[59], 1'b0);
    // Saturating count, then health against two thresholds
    fire(ev, 300);
    cmp(bank_status[39:32], CNT_MAX);
    apb(1'b0, OFS_COUNT, 32'h0, 4'h0);
    cmp(rd[7:0], CNT_MAX);
    apb(1'b1, OFS_CTRL, 32'h0000_1008, 4'hF);
    post(ev);
    cmp(bank_status[54:53], HEALTH_ABOVE);
    apb(1'b1, OFS_CTRL, 32'h0000_FF08, 4'hF);
    post(ev);
    apb(1'b0, OFS_STAT_HI, 32'h0, 4'h0);
    cmp({rd[31], rd[29], rd[22:21], rd[7:0]},
        {1'b1, 1'b0, HEALTH_BELOW, CNT_MAX});
    apb(1'b1, OFS_CTRL, CTRL_RESET, 4'hF);
    post(ev);
    cmp(bank_status[54:53], HEALTH_NONE);
    results();
  end
endmodule : bank_status_encoder_test
`default_nettype wire
